// ---- bst_consts.svh ----
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// ============================================================
// instruction layout and codes
`define BST_INS_W          4
`define BST_INS_EXTEST     4'h0
`define BST_INS_IDCODE     4'h1
`define BST_INS_FLOAT      4'h4
`define BST_INS_SAMPLE     4'h5
`define BST_INS_BYPASS     4'hF
`define BST_INS_CAPTURE    4'h1

// ============================================================
// identification word layout
`define BST_ID_W           32
`define BST_ID_LSB         1'h1
`define BST_BYP_CAPTURE    1'h0

// ============================================================
// tms-high count that always ends in test-logic-reset
`define BST_TMS_RESET_CNT  3'h5
`define BST_CNT_MAX        3'h7

`endif

// ---- bst_pkg.sv ----
package bst_pkg;

    // controller states, standard sixteen-state graph
    typedef enum logic [3:0] {
        st_tlr, st_rti, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr, st_upd_dr,
        st_sel_ins, st_cap_ins, st_sh_ins, st_ex1_ins, st_pa_ins, st_ex2_ins, st_upd_ins
    } bst_state_t;

    // test access port pins coming from the tester
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bst_pins_t;

    // decoded active instruction
    typedef struct packed {
        logic sel_chain;
        logic sel_id;
        logic extest;
        logic float_out;
    } bst_dec_t;

endpackage : bst_pkg

// ---- bst_sync.sv ----
`timescale 1ns/1ps

// three-stage synchroniser; the output level moves only once stages two and three agree
module bst_sync #(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] lvl
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] lvl_ff;
    logic [W-1:0] nxt_lvl;

    // ============================================================
    // accept a bit only when the last two stages agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
        end
    end

    // reset to zero keeps the tap held in reset until trst is seen high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff  <= d;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign lvl = lvl_ff;

endmodule : bst_sync

// ---- bst_tap.sv ----
`timescale 1ns/1ps
`include "bst_consts.svh"

// Function
// - sixteen-state controller, moves on tck rise
// - five tms-high rises reach test-logic-reset
// - trst low forces test-logic-reset once synchronised, no tck needed
// - reset state selects identification, normal pins
// - capture-dr loads selected data register
// - shift-dr shifts tdi toward tdo, driver on
// - update-dr loads output stage on fall
// - capture of instruction loads pattern 0001
// - instruction shift moves tdi toward tdo
// - instruction update latches hold stage on fall
// - pause holds data, exits only branch
// - run-test/idle holds all test registers
// - test logic independent, no self-test
// - instruction decoder plus chain, bypass, id
// - four-bit codes: extest, id, float, sample, bypass
// - bypass captures zero first out
// - 32-bit id word, bit zero one
module bst_tap #(
    parameter int          IN_W    = 4,
    parameter int          OUT_W   = 4,
    parameter logic [3:0]  ID_VER  = 4'h1,     // arbitrary value
    parameter logic [15:0] ID_PART = 16'hA5C3, // arbitrary value
    parameter logic [10:0] ID_MAKE = 11'h2AB   // arbitrary value
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire bst_pkg::bst_pins_t jtag_in,
    input  wire logic [IN_W-1:0]   pin_in,
    input  wire logic [OUT_W-1:0]  core_out,
    input  wire logic [OUT_W-1:0]  core_oe,
    output logic                   tdo,
    output logic                   tdo_oe,
    output logic      [OUT_W-1:0]  pin_out,
    output logic      [OUT_W-1:0]  pin_oe
);

    localparam int CH_W = IN_W + OUT_W;
    localparam logic [`BST_ID_W-1:0] ID_WORD = {ID_VER, ID_PART, ID_MAKE, `BST_ID_LSB};

    // ============================================================
    // functions
    function automatic bst_pkg::bst_state_t step(input bst_pkg::bst_state_t s, input logic tms);
        case (s)
            bst_pkg::st_tlr:     step = tms ? bst_pkg::st_tlr     : bst_pkg::st_rti;
            bst_pkg::st_rti:     step = tms ? bst_pkg::st_sel_dr  : bst_pkg::st_rti;
            bst_pkg::st_sel_dr:  step = tms ? bst_pkg::st_sel_ins : bst_pkg::st_cap_dr;
            bst_pkg::st_cap_dr:  step = tms ? bst_pkg::st_ex1_dr  : bst_pkg::st_sh_dr;
            bst_pkg::st_sh_dr:   step = tms ? bst_pkg::st_ex1_dr  : bst_pkg::st_sh_dr;
            bst_pkg::st_ex1_dr:  step = tms ? bst_pkg::st_upd_dr  : bst_pkg::st_pa_dr;
            bst_pkg::st_pa_dr:   step = tms ? bst_pkg::st_ex2_dr  : bst_pkg::st_pa_dr;
            bst_pkg::st_ex2_dr:  step = tms ? bst_pkg::st_upd_dr  : bst_pkg::st_sh_dr;
            bst_pkg::st_upd_dr:  step = tms ? bst_pkg::st_sel_dr  : bst_pkg::st_rti;
            bst_pkg::st_sel_ins: step = tms ? bst_pkg::st_tlr     : bst_pkg::st_cap_ins;
            bst_pkg::st_cap_ins: step = tms ? bst_pkg::st_ex1_ins : bst_pkg::st_sh_ins;
            bst_pkg::st_sh_ins:  step = tms ? bst_pkg::st_ex1_ins : bst_pkg::st_sh_ins;
            bst_pkg::st_ex1_ins: step = tms ? bst_pkg::st_upd_ins : bst_pkg::st_pa_ins;
            bst_pkg::st_pa_ins:  step = tms ? bst_pkg::st_ex2_ins : bst_pkg::st_pa_ins;
            bst_pkg::st_ex2_ins: step = tms ? bst_pkg::st_upd_ins : bst_pkg::st_sh_ins;
            bst_pkg::st_upd_ins: step = tms ? bst_pkg::st_sel_dr  : bst_pkg::st_rti;
            default:             step = bst_pkg::st_tlr;
        endcase
    endfunction : step

    // no self-test code exists; anything unlisted goes to bypass with pins floating
    function automatic bst_pkg::bst_dec_t decode(input logic [`BST_INS_W-1:0] c);
        decode = '0;
        case (c)
            `BST_INS_EXTEST: begin
                decode.sel_chain = 1'b1;
                decode.extest    = 1'b1;
            end
            `BST_INS_IDCODE: decode.sel_id    = 1'b1;
            `BST_INS_SAMPLE: decode.sel_chain = 1'b1;
            `BST_INS_BYPASS: decode.float_out = 1'b0;
            `BST_INS_FLOAT:  decode.float_out = 1'b1;
            default:         decode.float_out = 1'b1;
        endcase
    endfunction : decode

    // ============================================================
    // pin sampling and tck edge detection
    bst_pkg::bst_pins_t jt_lvl;
    logic               tck_prev_ff;
    logic               tck_rise;
    logic               tck_fall;

    bst_sync #(
        .W ($bits(bst_pkg::bst_pins_t))
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (jtag_in),
        .lvl     (jt_lvl)
    );

    assign tck_rise = jt_lvl.tck & ~tck_prev_ff;
    assign tck_fall = ~jt_lvl.tck & tck_prev_ff;

    // ============================================================
    // controller and test registers
    bst_pkg::bst_state_t   state_ff,     nxt_state;
    logic [`BST_INS_W-1:0] ins_sh_ff,    nxt_ins_sh;
    logic [`BST_INS_W-1:0] ins_hold_ff,  nxt_ins_hold;
    logic                  byp_ff,       nxt_byp;
    logic [`BST_ID_W-1:0]  id_sh_ff,     nxt_id_sh;
    logic [CH_W-1:0]       chain_sh_ff,  nxt_chain_sh;
    logic [CH_W-1:0]       chain_upd_ff, nxt_chain_upd;
    logic                  tdo_ff,       nxt_tdo;
    logic                  tdo_oe_ff,    nxt_tdo_oe;
    logic [OUT_W-1:0]      pin_out_ff,   nxt_pin_out;
    logic [OUT_W-1:0]      pin_oe_ff,    nxt_pin_oe;
    bst_pkg::bst_dec_t     dec;

    assign dec = decode(ins_hold_ff);

    // register actions happen on a detected tck edge, except trst low and the identification reload in test-logic-reset; idle, pause and exit states fall to hold
    always_comb begin
        nxt_state     = state_ff;
        nxt_ins_sh    = ins_sh_ff;
        nxt_ins_hold  = ins_hold_ff;
        nxt_byp       = byp_ff;
        nxt_id_sh     = id_sh_ff;
        nxt_chain_sh  = chain_sh_ff;
        nxt_chain_upd = chain_upd_ff;
        nxt_tdo       = tdo_ff;
        nxt_tdo_oe    = tdo_oe_ff;
        if (!jt_lvl.trst_n) begin
            nxt_state    = bst_pkg::st_tlr;
            nxt_ins_hold = `BST_INS_IDCODE;
            nxt_tdo_oe   = 1'b0;
        end else begin
            if (tck_rise) begin
                nxt_state = step(state_ff, jt_lvl.tms);
                case (state_ff)
                    bst_pkg::st_cap_dr: begin
                        if (dec.sel_chain) begin
                            nxt_chain_sh = {core_out, pin_in};
                        end else if (dec.sel_id) begin
                            nxt_id_sh = ID_WORD;
                        end else begin
                            nxt_byp = `BST_BYP_CAPTURE;
                        end
                    end
                    bst_pkg::st_sh_dr: begin
                        if (dec.sel_chain) begin
                            nxt_chain_sh = {jt_lvl.tdi, chain_sh_ff[CH_W-1:1]};
                        end else if (dec.sel_id) begin
                            nxt_id_sh = {jt_lvl.tdi, id_sh_ff[`BST_ID_W-1:1]};
                        end else begin
                            nxt_byp = jt_lvl.tdi;
                        end
                    end
                    bst_pkg::st_cap_ins: nxt_ins_sh = `BST_INS_CAPTURE;
                    bst_pkg::st_sh_ins: nxt_ins_sh = {jt_lvl.tdi, ins_sh_ff[`BST_INS_W-1:1]};
                    default: ;
                endcase
            end
            if (tck_fall) begin
                case (state_ff)
                    bst_pkg::st_upd_dr: begin
                        if (dec.sel_chain) begin
                            nxt_chain_upd = chain_sh_ff;
                        end
                    end
                    bst_pkg::st_upd_ins: nxt_ins_hold = ins_sh_ff;
                    default: ;
                endcase
                // tdo moves only on the fall so the tester samples a settled bit on the rise
                nxt_tdo_oe = (state_ff == bst_pkg::st_sh_dr) || (state_ff == bst_pkg::st_sh_ins);
                if (state_ff == bst_pkg::st_sh_ins) begin
                    nxt_tdo = ins_sh_ff[0];
                end else if (dec.sel_chain) begin
                    nxt_tdo = chain_sh_ff[0];
                end else if (dec.sel_id) begin
                    nxt_tdo = id_sh_ff[0];
                end else begin
                    nxt_tdo = byp_ff;
                end
            end
            if (state_ff == bst_pkg::st_tlr) begin
                nxt_ins_hold = `BST_INS_IDCODE;
            end
        end
    end

    // ============================================================
    // pin output cells; only this mux is shared with the application path
    always_comb begin
        nxt_pin_out = core_out;
        nxt_pin_oe  = core_oe;
        if (dec.float_out) begin
            nxt_pin_oe = '0;
        end else if (dec.extest) begin
            nxt_pin_out = chain_upd_ff[CH_W-1:IN_W];
            nxt_pin_oe  = '1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= bst_pkg::st_tlr;
            ins_sh_ff    <= `BST_INS_IDCODE;
            ins_hold_ff  <= `BST_INS_IDCODE;
            byp_ff       <= 1'b0;
            id_sh_ff     <= '0;
            chain_sh_ff  <= '0;
            chain_upd_ff <= '0;
            tdo_ff       <= 1'b0;
            tdo_oe_ff    <= 1'b0;
            pin_out_ff   <= '0;
            pin_oe_ff    <= '0;
            tck_prev_ff  <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            ins_sh_ff    <= nxt_ins_sh;
            ins_hold_ff  <= nxt_ins_hold;
            byp_ff       <= nxt_byp;
            id_sh_ff     <= nxt_id_sh;
            chain_sh_ff  <= nxt_chain_sh;
            chain_upd_ff <= nxt_chain_upd;
            tdo_ff       <= nxt_tdo;
            tdo_oe_ff    <= nxt_tdo_oe;
            pin_out_ff   <= nxt_pin_out;
            pin_oe_ff    <= nxt_pin_oe;
            tck_prev_ff  <= jt_lvl.tck;
        end
    end

    assign tdo     = tdo_ff;
    assign tdo_oe  = tdo_oe_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe  = pin_oe_ff;

    // ============================================================
    // checks
    logic [2:0] tms_cnt_ff;
    logic [2:0] nxt_tms_cnt;

    // counts consecutive tck rises with tms high
    always_comb begin
        nxt_tms_cnt = tms_cnt_ff;
        if (!jt_lvl.trst_n) begin
            nxt_tms_cnt = '0;
        end else if (tck_rise) begin
            nxt_tms_cnt = !jt_lvl.tms ? 3'h0 : (tms_cnt_ff == `BST_CNT_MAX) ? tms_cnt_ff : tms_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tms_cnt_ff <= '0;
        end else begin
            tms_cnt_ff <= nxt_tms_cnt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_trst_forces_tlr: assert property (!jt_lvl.trst_n |=> state_ff == bst_pkg::st_tlr)
        else $error("trst low did not force test-logic-reset");
    a_tms_five_reset: assert property (tms_cnt_ff >= `BST_TMS_RESET_CNT |-> state_ff == bst_pkg::st_tlr)
        else $error("five tms-high rises did not reach test-logic-reset");
    a_state_only_rise: assert property (jt_lvl.trst_n && !tck_rise |=> $stable(state_ff))
        else $error("state moved without a tck rise");
    a_tlr_loads_id: assert property (state_ff == bst_pkg::st_tlr |=> ins_hold_ff == `BST_INS_IDCODE)
        else $error("test-logic-reset did not select identification");
    a_cap_ins_pattern: assert property (jt_lvl.trst_n && tck_rise && state_ff == bst_pkg::st_cap_ins
                                        |=> ins_sh_ff == `BST_INS_CAPTURE)
        else $error("instruction capture pattern wrong");
    a_upd_ins_latch: assert property (jt_lvl.trst_n && tck_fall && state_ff == bst_pkg::st_upd_ins
                                      |=> ins_hold_ff == $past(ins_sh_ff))
        else $error("instruction update did not latch");
    a_id_capture: assert property (jt_lvl.trst_n && tck_rise && state_ff == bst_pkg::st_cap_dr && dec.sel_id
                                   |=> id_sh_ff == ID_WORD && id_sh_ff[0])
        else $error("identification word not captured");
    a_byp_capture: assert property (jt_lvl.trst_n && tck_rise && state_ff == bst_pkg::st_cap_dr
                                    && !dec.sel_id && !dec.sel_chain |=> !byp_ff)
        else $error("bypass did not capture zero");
    a_pause_holds: assert property (state_ff == bst_pkg::st_pa_dr |=> $stable(chain_sh_ff) && $stable(id_sh_ff))
        else $error("data shifted during pause");
    a_tdo_drive_shift: assert property (jt_lvl.trst_n && tck_fall |=>
                                        tdo_oe_ff == ($past(state_ff) inside {bst_pkg::st_sh_dr, bst_pkg::st_sh_ins}))
        else $error("tdo enable wrong after tck fall");
    a_float_pins: assert property (dec.float_out |=> pin_oe_ff == '0)
        else $error("outputs not floated");

    c_id_read: cover property (tck_rise && state_ff == bst_pkg::st_sh_dr && dec.sel_id);
    c_ins_update: cover property (tck_fall && state_ff == bst_pkg::st_upd_ins);
    c_extest_drive: cover property (dec.extest && tck_fall && state_ff == bst_pkg::st_upd_dr);

endmodule : bst_tap

// ---- bst_tester.sv ----
`timescale 1ns/1ps

// ============================================================
// tester model: drives the test port, reads tdo back
module bst_tester (
    input  wire logic          ref_clk,
    input  wire logic          tdo,
    input  wire logic          tdo_oe,
    output bst_pkg::bst_pins_t jtag
);
    // tck rests low between frames, trst_n released high
    initial begin
        jtag = 4'h5;
    end

    // one 400 ns tck period; tdo is read just before the fall because the
    // device answers several ref_clk after each fall
    task automatic tick(input logic tms, input logic tdi, output logic so, output logic soe);
        jtag.tms = tms;
        jtag.tdi = tdi;
        repeat (4) @(posedge ref_clk);
        #1 jtag.tck = 1'h1;
        repeat (4) @(posedge ref_clk);
        #1 so = tdo;
        soe = tdo_oe;
        jtag.tck = 1'h0;
    endtask : tick

    // walk the controller with a tms sequence, lsb first
    task automatic walk(input logic [7:0] tms_seq, input int n);
        logic so;
        logic soe;
        for (int i = 0; i < n; i++) begin
            tick(tms_seq[i], 1'h0, so, soe);
        end
    endtask : walk

    // five tms-high periods end in test-logic-reset from anywhere
    task automatic to_reset();
        walk(8'hFF, 5);
    endtask : to_reset

    // load an instruction, return the captured pattern; ends in run-test/idle
    task automatic ir_load(input logic [3:0] code, output logic [3:0] cap, output logic oe_ok);
        logic so;
        logic soe;
        oe_ok = 1'h1;
        walk(8'h06, 5);
        for (int i = 0; i < 4; i++) begin
            tick(i == 3, code[i], cap[i], soe);
            oe_ok &= soe;
        end
        tick(1'h1, 1'h0, so, soe);
        oe_ok &= ~soe;
        walk(8'h00, 1);
    endtask : ir_load

    // shift n data bits, optional pause after bit pause_at; ends in run-test/idle
    task automatic dr_shift(input int n, input logic [31:0] din, input int pause_at,
                            output logic [31:0] dout, output logic oe_ok);
        logic so;
        logic soe;
        dout = 32'h0;
        oe_ok = 1'h1;
        walk(8'h02, 4);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1 || i == pause_at, din[i], dout[i], soe);
            oe_ok &= soe;
            if (i == pause_at) begin
                walk(8'h04, 4);
            end
        end
        tick(1'h1, 1'h0, so, soe);
        oe_ok &= ~soe;
        walk(8'h00, 1);
    endtask : dr_shift

    // asynchronous test reset; tdi shows a changed level while released
    task automatic hold_trst(input int cycles);
        jtag.trst_n = 1'h0;
        jtag.tdi = ~jtag.tdi;
        repeat (cycles) @(posedge ref_clk);
        #1 jtag.trst_n = 1'h1;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : hold_trst
endmodule : bst_tester

// ---- boundary_scan_tap_controller_bench.sv ----
`timescale 1ns/1ps

module boundary_scan_tap_controller_bench;
    localparam logic [3:0]  id_ver  = 4'h3;     // arbitrary value
    localparam logic [15:0] id_part = 16'h5A96; // arbitrary value
    localparam logic [10:0] id_make = 11'h155;  // arbitrary value
    localparam logic [31:0] id_word = {id_ver, id_part, id_make, 1'h1};

    logic               ref_clk;
    logic               rst_n;
    bst_pkg::bst_pins_t jtag;
    logic [3:0]         pin_in;
    logic [3:0]         core_out;
    logic [3:0]         core_oe;
    logic               tdo;
    logic               tdo_oe;
    logic [3:0]         pin_out;
    logic [3:0]         pin_oe;
    int                 n_mismatch;
    int                 tests_run;
    logic [3:0]         ins_cap;
    logic               ins_ok;

    bst_tap #(.IN_W(4), .OUT_W(4), .ID_VER(id_ver), .ID_PART(id_part), .ID_MAKE(id_make)) i_bst_tap (
        .ref_clk(ref_clk), .rst_n(rst_n), .jtag_in(jtag), .pin_in(pin_in), .core_out(core_out),
        .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .pin_out(pin_out), .pin_oe(pin_oe));

    bst_tester i_bst_tester (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .jtag(jtag));

    // ============================================================
    // clock, compare and closing
    always #25 ref_clk = ~ref_clk;

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_pins(input logic [3:0] eo, input logic [3:0] ee);
        check_word("pin_out", {28'h0, eo}, {28'h0, pin_out});
        check_word("pin_oe", {28'h0, ee}, {28'h0, pin_oe});
    endtask : check_pins

    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // ============================================================
    // scenarios
    task automatic read_id(input string what, input int pause_at);
        logic [31:0] d;
        logic        ok;
        i_bst_tester.dr_shift(32, 32'h0, pause_at, d, ok);
        check_word(what, id_word, d);
        check_word("tdo enable in data shift", 32'h1, {31'h0, ok});
    endtask : read_id

    task automatic t_bypass();
        logic [3:0]  cap;
        logic [31:0] d;
        logic        ok;
        i_bst_tester.ir_load(4'hF, cap, ok);
        check_word("instruction capture", 32'h1, {28'h0, cap});
        check_word("tdo enable in ins shift", 32'h1, {31'h0, ok});
        i_bst_tester.dr_shift(8, 32'hB5, -1, d, ok);
        check_word("bypass shift", 32'h6A, d);
        check_pins(core_out, core_oe);
    endtask : t_bypass

    // float and unlisted codes: outputs off, one-stage path
    task automatic t_float_unlisted();
        logic [3:0]  codes [4] = '{4'h4, 4'h2, 4'h9, 4'hE};
        logic [3:0]  cap;
        logic [31:0] d;
        logic        ok;
        for (int k = 0; k < 4; k++) begin
            i_bst_tester.ir_load(codes[k], cap, ok);
            check_word("pin_oe floated", 32'h0, {28'h0, pin_oe});
            i_bst_tester.dr_shift(2, 32'h3, -1, d, ok);
            check_word("float path", 32'h2, d);
        end
    endtask : t_float_unlisted

    // sample then preload, extest drives pins from the update stage only
    task automatic t_sample_extest();
        logic [3:0]  cap;
        logic [31:0] d;
        logic        ok;
        i_bst_tester.ir_load(4'h5, cap, ok);
        i_bst_tester.dr_shift(8, 32'h3C, -1, d, ok);
        check_word("sample capture", 32'h65, d);
        check_pins(core_out, core_oe);
        i_bst_tester.ir_load(4'h0, cap, ok);
        check_pins(4'h3, 4'hF);
        core_out = 4'hC;
        repeat (3) @(posedge ref_clk);
        #1 check_pins(4'h3, 4'hF);
        i_bst_tester.dr_shift(8, 32'hA1, -1, d, ok);
        check_word("extest capture", 32'hC5, d);
        check_pins(4'hA, 4'hF);
        i_bst_tester.walk(8'h00, 4);
        check_pins(4'hA, 4'hF);
    endtask : t_sample_extest

    // five tms-high periods from shift-ir, then stay in reset
    task automatic t_tms_reset();
        i_bst_tester.walk(8'h06, 5);
        i_bst_tester.to_reset();
        // the pass through update-ir latches a zeroed code; reset state reloads identification a few cycles later
        repeat (4) @(posedge ref_clk);
        #1 check_pins(core_out, core_oe);
        i_bst_tester.walk(8'hFF, 3);
        read_id("id after tms reset", -1);
    endtask : t_tms_reset

    // trst in mid data shift with extest active
    task automatic t_trst();
        logic [3:0] cap;
        logic       ok;
        i_bst_tester.ir_load(4'h0, cap, ok);
        i_bst_tester.walk(8'h02, 4);
        repeat (8) @(posedge ref_clk);
        #1 check_word("tdo_oe in shift", 32'h1, {31'h0, tdo_oe});
        i_bst_tester.hold_trst(12);
        check_word("tdo_oe after trst", 32'h0, {31'h0, tdo_oe});
        check_pins(core_out, core_oe);
        read_id("id after trst", -1);
    endtask : t_trst

    // watchdog: the run needs roughly 0.14 ms
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end

    // main sequence
    initial begin
        ref_clk = 1'h0;
        rst_n = 1'h0;
        pin_in = 4'h5;
        core_out = 4'h6;
        core_oe = 4'h9;
        n_mismatch = 0;
        tests_run = 0;
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'h1;
        repeat (10) @(posedge ref_clk);
        #1 check_pins(core_out, core_oe);
        read_id("id after reset", -1);
        t_bypass();
        t_float_unlisted();
        t_sample_extest();
        i_bst_tester.ir_load(4'h1, ins_cap, ins_ok);
        check_word("instruction capture", 32'h1, {28'h0, ins_cap});
        check_word("tdo enable in ins shift", 32'h1, {31'h0, ins_ok});
        read_id("id across pause", 12);
        t_tms_reset();
        t_trst();
        report_and_stop();
    end
endmodule : boundary_scan_tap_controller_bench
